/* File: pkg/aec_pkg.sv */
// Package of register map, field positions and reset values for the event counter control
// What this block does
// (R1) Gate pin edge: 00 fall, 01 rise, 10 both
// (R2) PWM enable off: pin gates; on: PWM gates
// (R3) Reserved bits read/write, reset to zero
// (R4) High clock select: pin, /2, /4, /8
// (R5) Low clock select: pin, /2, /4, /8
// (R6) PWM clock: /2../16, top set gives /32 or /64
// (R7) Control/status register resets to zero
// (R8) High overflow flag set on FF to 00
// (R9) Low overflow flag set on FF to 00
// (R10) Software writing one never sets flags
// (R11) Flag clears by read-one then write-zero
// (R12) Joined mode: high flag marks FFFF wrap
// (R13) Counters advance only while gate is high
// (R14) Mode 0 chains low into high counter
// (R15) Overflow beats simultaneous clear
package aec_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_EDGE_SEL   = 4'h0;
  localparam logic [3:0] OFS_CLK_CTL    = 4'h1;
  localparam logic [3:0] OFS_CTL_STAT   = 4'h2;
  localparam logic [3:0] OFS_HIGH_CNT   = 4'h3;
  localparam logic [3:0] OFS_LOW_CNT    = 4'h4;
  localparam logic [3:0] OFS_IRQ_STAT   = 4'h5;
  localparam logic [3:0] OFS_IRQ_MASK   = 4'h6;
  localparam logic [3:0] OFS_PWM_PERIOD = 4'h7;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_EDGE_SEL   = 8'h00;
  localparam logic [7:0] RST_CLK_CTL    = 8'h00;
  localparam logic [7:0] RST_CTL_STAT   = 8'h00;
  localparam logic [7:0] RST_PWM_PERIOD = 8'hFF;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GATE_EDGE_HI = 3;
  localparam int GATE_EDGE_LO = 2;
  localparam int PWM_EN_BIT   = 1;
  localparam int HCLK_HI      = 7;
  localparam int HCLK_LO      = 6;
  localparam int LCLK_HI      = 5;
  localparam int LCLK_LO      = 4;
  localparam int PWCK_HI      = 3;
  localparam int PWCK_LO      = 1;
  localparam int OVH_BIT      = 7;
  localparam int OVL_BIT      = 6;
  localparam int SPLIT_BIT    = 4;
  localparam int HIGH_COUNT_ENABLE_BIT     = 3;
  localparam int LOW_COUNT_ENABLE_BIT     = 2;
  localparam int HIGH_COUNTER_RESET_CTL_BIT     = 1;
  localparam int LOW_COUNTER_RESET_CTL_BIT     = 0;
  // Interrupt status bits
  localparam int IRQ_OVL      = 0;
  localparam int IRQ_OVH      = 1;
  localparam int IRQ_GATE     = 2;
  // Prescaler width: enough for divide by 64
  localparam int PRE_W        = 6;
  // ----------------------------------------------------------------
  // Edge codes
  // ----------------------------------------------------------------
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
endpackage : aec_pkg

/* File: pkg/aec_tick_if.sv */
// Interface carrying prescaler ticks from the divider to the counter logic
`timescale 1ns/1ns
interface aec_tick_if;
  logic       div2;
  logic       div4;
  logic       div8;
  logic       div16;
  logic       div32;
  logic       div64;
  modport src (output div2, div4, div8, div16, div32, div64);
  modport dst (input  div2, div4, div8, div16, div32, div64);
endinterface : aec_tick_if

/* File: rtl/aec_prescaler.sv */
// Free running prescaler producing one-cycle ticks at phi/2 to phi/64
`timescale 1ns/1ns
module aec_prescaler
  import aec_pkg::*;
(
  // Clock and reset
  input  wire logic CLK_SYS_I,
  input  wire logic RESET_N_I,
  // Ticks
  aec_tick_if.src   tick
);
  logic [PRE_W-1:0] pre;
  logic [PRE_W-1:0] next_pre;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  assign next_pre = pre + 6'h01;

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      pre <= '0;
    end else begin
      pre <= next_pre;
    end
  end

  // A tick fires when the low bits are all ones, the cycle before they roll over to zero
  assign tick.div2  = (pre[0]   == 1'h1);
  assign tick.div4  = (pre[1:0] == 2'h3);
  assign tick.div8  = (pre[2:0] == 3'h7);
  assign tick.div16 = (pre[3:0] == 4'hF);
  assign tick.div32 = (pre[4:0] == 5'h1F);
  assign tick.div64 = (pre[5:0] == 6'h3F);
endmodule : aec_prescaler

/* File: rtl/aec_event_ctrl.sv */
// Event counter control, status flags, gating and register port
`timescale 1ns/1ns
module aec_event_ctrl
  import aec_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK_SYS_I,
  input  wire logic       RESET_N_I,
  // Register port
  input  wire logic [3:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  output logic      [7:0] REG_RDATA_O,
  // Event pins
  input  wire logic       EVENT_GATE_IRQ_PIN_I,
  input  wire logic       HIGH_EVENT_PIN_I,
  input  wire logic       LOW_EVENT_PIN_I,
  // Status outputs
  output logic            PWM_GATE_SIGNAL_O,
  output logic            COUNT_GATE_O,
  output logic            IRQ_O
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  aec_tick_if tick ();

  logic [7:0] input_edge_select;
  logic [7:0] counter_clock_control;
  logic [7:0] counter_control_status;
  logic [7:0] pwm_period;
  logic [7:0] high_event_counter;
  logic [7:0] low_event_counter;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [7:0] pwm_cnt;
  logic       pwm_gate_signal;
  logic [2:0] gate_sync;
  logic [2:0] hpin_sync;
  logic [2:0] lpin_sync;
  logic       gate_lvl;
  logic       hpin_lvl;
  logic       lpin_lvl;
  logic       ovh_armed;
  logic       ovl_armed;
  logic       gate_edge;
  logic       count_gate;
  logic       pwm_tick;
  logic       low_src;
  logic       high_src;
  logic       low_inc;
  logic       high_inc;
  logic       low_wrap;
  logic       high_wrap;
  logic       wr_cs;
  logic       ovh_clr;
  logic       ovl_clr;
  logic [7:0] next_rdata;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic edge_hit(input logic [1:0] code, input logic prev,
                                    input logic cur);
    case (code)
      EDGE_FALL: edge_hit = prev & ~cur; // (R1)
      EDGE_RISE: edge_hit = ~prev & cur; // (R1)
      EDGE_BOTH: edge_hit = prev ^ cur;  // (R1)
      default:   edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  // Pin edge uses same coding; sel 00 means the pin, others the prescaler
  function automatic logic clk_src(input logic [1:0] sel, input logic pin_ev);
    case (sel)
      2'h0:    clk_src = pin_ev;
      2'h1:    clk_src = tick.div2;
      2'h2:    clk_src = tick.div4;
      default: clk_src = tick.div8;
    endcase
  endfunction : clk_src

  aec_prescaler u_pre (
    .CLK_SYS_I (CLK_SYS_I),
    .RESET_N_I (RESET_N_I),
    .tick      (tick)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers, stage 0 read only by stage 1
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      gate_sync <= '0;
      hpin_sync <= '0;
      lpin_sync <= '0;
      gate_lvl  <= 1'b0;
      hpin_lvl  <= 1'b0;
      lpin_lvl  <= 1'b0;
    end else begin
      gate_sync <= {gate_sync[1:0], EVENT_GATE_IRQ_PIN_I};
      hpin_sync <= {hpin_sync[1:0], HIGH_EVENT_PIN_I};
      lpin_sync <= {lpin_sync[1:0], LOW_EVENT_PIN_I};
      if (gate_sync[1] == gate_sync[2]) begin
        gate_lvl <= gate_sync[2];
      end
      if (hpin_sync[1] == hpin_sync[2]) begin
        hpin_lvl <= hpin_sync[2];
      end
      if (lpin_sync[1] == lpin_sync[2]) begin
        lpin_lvl <= lpin_sync[2];
      end
    end
  end

  assign gate_edge = (gate_sync[1] == gate_sync[2]) &&
                     edge_hit(input_edge_select[GATE_EDGE_HI:GATE_EDGE_LO],
                              gate_lvl, gate_sync[2]);

  // ----------------------------------------------------------------
  // PWM gate: square wave over period, clocked by selected tick
  // ----------------------------------------------------------------
  always_comb begin
    if (counter_clock_control[PWCK_HI]) begin
      pwm_tick = counter_clock_control[PWCK_LO] ? tick.div64 : tick.div32; // (R6)
    end else begin
      case (counter_clock_control[PWCK_HI-1:PWCK_LO])
        2'h0:    pwm_tick = tick.div2;  // (R6)
        2'h1:    pwm_tick = tick.div4;  // (R6)
        2'h2:    pwm_tick = tick.div8;  // (R6)
        default: pwm_tick = tick.div16; // (R6)
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      pwm_cnt         <= '0;
      pwm_gate_signal <= 1'b0;
    end else if (!input_edge_select[PWM_EN_BIT]) begin
      pwm_cnt         <= '0; // (R2)
      pwm_gate_signal <= 1'b0;
    end else if (pwm_tick) begin
      pwm_cnt         <= (pwm_cnt >= pwm_period) ? 8'h00 : pwm_cnt + 8'h01;
      pwm_gate_signal <= (pwm_cnt < {1'b0, pwm_period[7:1]});
    end
  end

  // Pin selected as gate only while PWM is off
  assign count_gate = input_edge_select[PWM_EN_BIT] ? pwm_gate_signal : gate_lvl; // (R2)

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  assign low_src  = clk_src(counter_clock_control[LCLK_HI:LCLK_LO], // (R5)
                    edge_hit(input_edge_select[5:4], lpin_lvl, lpin_sync[2]) &&
                    (lpin_sync[1] == lpin_sync[2]));
  assign low_inc  = count_gate && low_src && counter_control_status[LOW_COUNT_ENABLE_BIT]
                    && counter_control_status[LOW_COUNTER_RESET_CTL_BIT]; // (R13)
  assign low_wrap = low_inc && (low_event_counter == 8'hFF);
  assign high_src = counter_control_status[SPLIT_BIT]
                  ? clk_src(counter_clock_control[HCLK_HI:HCLK_LO], // (R4)
                    edge_hit(input_edge_select[7:6], hpin_lvl, hpin_sync[2]) &&
                    (hpin_sync[1] == hpin_sync[2]))
                  : low_wrap; // (R14)
  assign high_inc = (count_gate || !counter_control_status[SPLIT_BIT]) && high_src
                    && counter_control_status[HIGH_COUNT_ENABLE_BIT]
                    && counter_control_status[HIGH_COUNTER_RESET_CTL_BIT]; // (R13)
  assign high_wrap = high_inc && (high_event_counter == 8'hFF); // (R12)

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      low_event_counter  <= '0;
      high_event_counter <= '0;
    end else begin
      if (!counter_control_status[LOW_COUNTER_RESET_CTL_BIT]) begin
        low_event_counter <= '0;
      end else if (low_inc) begin
        low_event_counter <= low_event_counter + 8'h01;
      end
      if (!counter_control_status[HIGH_COUNTER_RESET_CTL_BIT]) begin
        high_event_counter <= '0;
      end else if (high_inc) begin
        high_event_counter <= high_event_counter + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  assign wr_cs   = REG_WR_I && (REG_ADDR_I == OFS_CTL_STAT);
  assign ovh_clr = wr_cs && ovh_armed && !REG_WDATA_I[OVH_BIT]; // (R11)
  assign ovl_clr = wr_cs && ovl_armed && !REG_WDATA_I[OVL_BIT]; // (R11)

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      input_edge_select     <= RST_EDGE_SEL;   // (R3)
      counter_clock_control <= RST_CLK_CTL;    // (R3)
      pwm_period            <= RST_PWM_PERIOD;
      irq_mask              <= '0;
    end else if (REG_WR_I) begin
      case (REG_ADDR_I)
        OFS_EDGE_SEL:   input_edge_select     <= REG_WDATA_I; // (R3)
        OFS_CLK_CTL:    counter_clock_control <= REG_WDATA_I; // (R3)
        OFS_PWM_PERIOD: pwm_period            <= REG_WDATA_I;
        OFS_IRQ_MASK:   irq_mask              <= REG_WDATA_I[2:0];
        default: ;
      endcase
    end
  end

  // Control bits plainly written; flags only cleared, never set by software
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      counter_control_status <= RST_CTL_STAT; // (R7)
    end else begin
      if (wr_cs) begin
        counter_control_status[5:0] <= REG_WDATA_I[5:0]; // (R3)
      end
      counter_control_status[OVH_BIT] <= high_wrap |
        (counter_control_status[OVH_BIT] & ~ovh_clr); // (R8) (R10) (R15)
      counter_control_status[OVL_BIT] <= low_wrap |
        (counter_control_status[OVL_BIT] & ~ovl_clr); // (R9) (R10) (R15)
    end
  end

  // Arming remembers a read that saw the flag at one
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      ovh_armed <= 1'b0;
      ovl_armed <= 1'b0;
    end else if (REG_RD_I && (REG_ADDR_I == OFS_CTL_STAT)) begin
      ovh_armed <= counter_control_status[OVH_BIT]; // (R11)
      ovl_armed <= counter_control_status[OVL_BIT]; // (R11)
    end else begin
      if (ovh_clr || !counter_control_status[OVH_BIT]) begin
        ovh_armed <= 1'b0;
      end
      if (ovl_clr || !counter_control_status[OVL_BIT]) begin
        ovl_armed <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts: set wins over write-one clear
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      irq_stat <= '0;
    end else begin
      irq_stat[IRQ_OVL]  <= low_wrap | (irq_stat[IRQ_OVL] &
        ~(REG_WR_I && REG_ADDR_I == OFS_IRQ_STAT && REG_WDATA_I[IRQ_OVL]));
      irq_stat[IRQ_OVH]  <= high_wrap | (irq_stat[IRQ_OVH] &
        ~(REG_WR_I && REG_ADDR_I == OFS_IRQ_STAT && REG_WDATA_I[IRQ_OVH]));
      irq_stat[IRQ_GATE] <= (gate_edge && !input_edge_select[PWM_EN_BIT]) |
        (irq_stat[IRQ_GATE] &
        ~(REG_WR_I && REG_ADDR_I == OFS_IRQ_STAT && REG_WDATA_I[IRQ_GATE]));
    end
  end

  // ----------------------------------------------------------------
  // Read data and outputs
  // ----------------------------------------------------------------
  always_comb begin
    case (REG_ADDR_I)
      OFS_EDGE_SEL:   next_rdata = input_edge_select;
      OFS_CLK_CTL:    next_rdata = counter_clock_control;
      OFS_CTL_STAT:   next_rdata = counter_control_status;
      OFS_HIGH_CNT:   next_rdata = high_event_counter;
      OFS_LOW_CNT:    next_rdata = low_event_counter;
      OFS_IRQ_STAT:   next_rdata = {5'h00, irq_stat};
      OFS_IRQ_MASK:   next_rdata = {5'h00, irq_mask};
      OFS_PWM_PERIOD: next_rdata = pwm_period;
      default:        next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O       <= 8'h00;
      PWM_GATE_SIGNAL_O <= 1'b0;
      COUNT_GATE_O      <= 1'b0;
      IRQ_O             <= 1'b0;
    end else begin
      REG_RDATA_O       <= REG_RD_I ? next_rdata : 8'h00;
      PWM_GATE_SIGNAL_O <= pwm_gate_signal;
      COUNT_GATE_O      <= count_gate;
      IRQ_O             <= |(irq_stat & irq_mask);
    end
  end
endmodule : aec_event_ctrl

/* File: test/aec_pin_src.sv */
// Model of the external event sources that drive the gate and event pins
`timescale 1ns/1ns
module aec_pin_src (
  // Pins toward the device
  output logic GATE_O,
  output logic HIGH_O,
  output logic LOW_O
);
  initial begin
    GATE_O = 1'b0;
    HIGH_O = 1'b1;
    LOW_O  = 1'b1;
  end
  // Pins change a fixed delay after each call, between clock edges
  task automatic set_gate(input logic v);
    #13 GATE_O = v;
    #500;
  endtask : set_gate
  // Each pulse gives one falling and one rising edge on every chosen pin
  task automatic pulse(input logic hi, input logic lo, input int n);
    repeat (n) begin
      #500;
      HIGH_O = HIGH_O ^ hi;
      LOW_O  = LOW_O ^ lo;
      #500;
      HIGH_O = HIGH_O ^ hi;
      LOW_O  = LOW_O ^ lo;
    end
    #500;
  endtask : pulse
endmodule : aec_pin_src

/* File: test/aec_monitor.sv */
// Checker of register readback, count gating and interrupt output at the top ports
`timescale 1ns/1ns
module aec_monitor
  import aec_pkg::*;
(
  // Clock and reset
  input wire logic       CLK_SYS_I,
  input wire logic       RESET_N_I,
  // Register port
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic       REG_WR_I,
  input wire logic       REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  // Pins and status
  input wire logic       EVENT_GATE_IRQ_PIN_I,
  input wire logic       PWM_GATE_SIGNAL_O,
  input wire logic       COUNT_GATE_O,
  input wire logic       IRQ_O
);
  // ----------------------------------------------------------------
  // Shadow state
  // ----------------------------------------------------------------
  logic [7:0] sh_es, sh_cc;
  logic [5:0] sh_cs;
  logic [2:0] sh_mk;
  logic [3:0] quiet;
  logic       pin_q, rd_d;
  logic [1:0] last, cs_wr, keep;
  assign keep = last & ~cs_wr;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      sh_es <= RST_EDGE_SEL;
      sh_cc <= RST_CLK_CTL;
      sh_cs <= RST_CTL_STAT[5:0];
      sh_mk <= 3'h0;
    end else if (REG_WR_I) begin
      if (REG_ADDR_I == OFS_EDGE_SEL) sh_es <= REG_WDATA_I;
      if (REG_ADDR_I == OFS_CLK_CTL) sh_cc <= REG_WDATA_I;
      if (REG_ADDR_I == OFS_CTL_STAT) sh_cs <= REG_WDATA_I[5:0];
      if (REG_ADDR_I == OFS_IRQ_MASK) sh_mk <= REG_WDATA_I[2:0];
    end
  end
  // Gate settles a few cycles after a pin or mode change, so wait it out
  always_ff @(posedge CLK_SYS_I) begin
    pin_q <= EVENT_GATE_IRQ_PIN_I;
    if (!RESET_N_I || pin_q != EVENT_GATE_IRQ_PIN_I
        || (REG_WR_I && REG_ADDR_I == OFS_EDGE_SEL)) quiet <= 4'h0;
    else if (quiet != 4'hF) quiet <= quiet + 4'h1;
  end
  // Flags seen set by the last read, and zero-writes to them since
  always_ff @(posedge CLK_SYS_I) begin
    rd_d <= RESET_N_I && REG_RD_I && REG_ADDR_I == OFS_CTL_STAT;
    if (!RESET_N_I) begin
      last  <= 2'h0;
      cs_wr <= 2'h0;
    end else begin
      if (rd_d) last <= REG_RDATA_O[7:6];
      if (rd_d) cs_wr <= 2'h0;
      // A zero-write right after the read starts the new tally afresh
      if (REG_WR_I && REG_ADDR_I == OFS_CTL_STAT)
        cs_wr <= (rd_d ? 2'h0 : cs_wr) | ~REG_WDATA_I[7:6];
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  edge_sel_read_a: assert property (
    REG_RD_I && REG_ADDR_I == OFS_EDGE_SEL |=> REG_RDATA_O == $past(sh_es))
    else $error("edge select readback wrong");
  clk_ctl_read_a: assert property (
    REG_RD_I && REG_ADDR_I == OFS_CLK_CTL |=> REG_RDATA_O == $past(sh_cc))
    else $error("clock control readback wrong");
  ctl_bits_read_a: assert property (
    REG_RD_I && REG_ADDR_I == OFS_CTL_STAT |=> REG_RDATA_O[5:0] == $past(sh_cs))
    else $error("control bits readback wrong");
  flag_sticky_a: assert property (
    REG_RD_I && REG_ADDR_I == OFS_CTL_STAT |=> (REG_RDATA_O[7:6] & keep) == keep)
    else $error("overflow flag lost without clearing sequence");
  gate_pin_a: assert property (
    quiet > 4'h7 && !sh_es[PWM_EN_BIT] |-> COUNT_GATE_O == pin_q)
    else $error("count gate does not follow gate pin");
  gate_pwm_a: assert property (
    quiet > 4'h7 && sh_es[PWM_EN_BIT]
    |-> COUNT_GATE_O == PWM_GATE_SIGNAL_O)
    else $error("count gate does not follow pwm gate");
  irq_masked_a: assert property (
    sh_mk == 3'h0 && $past(sh_mk) == 3'h0 |-> !IRQ_O)
    else $error("interrupt raised while fully masked");
  irq_follows_a: assert property (
    REG_RD_I && REG_ADDR_I == OFS_IRQ_STAT |=> IRQ_O == |(REG_RDATA_O[2:0] & $past(sh_mk)))
    else $error("interrupt output disagrees with status and mask");
endmodule : aec_monitor

bind aec_event_ctrl aec_monitor u_mon (
  .CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O), .EVENT_GATE_IRQ_PIN_I(EVENT_GATE_IRQ_PIN_I),
  .PWM_GATE_SIGNAL_O(PWM_GATE_SIGNAL_O), .COUNT_GATE_O(COUNT_GATE_O), .IRQ_O(IRQ_O)
);

/* File: test/tb_top.sv */
// Self-checking bench for the event counter control block
`timescale 1ns/1ns
module tb_top;
  import aec_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic       CLK_SYS_I   = 1'b0;
  logic       RESET_N_I   = 1'b0;
  logic [3:0] REG_ADDR_I;
  logic [7:0] REG_WDATA_I;
  logic       REG_WR_I    = 1'b0;
  logic       REG_RD_I    = 1'b0;
  logic [7:0] REG_RDATA_O;
  logic       gate_pin, high_pin, low_pin, pwm_gate, count_gate, irq;
  logic [7:0] d, e;
  int         mismatches  = 0;
  int         checks_done = 0;
  int         cycles      = 0;
  // Edge codes 00, 01, 10 with PWM off, then PWM on; code 11 is never used
  logic [7:0] es_tab [4]  = '{8'h00, 8'h04, 8'h08, 8'h02};
  logic       rise_tab [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic       fall_tab [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  always #25 CLK_SYS_I = ~CLK_SYS_I;
  aec_event_ctrl u_dut (
    .CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .EVENT_GATE_IRQ_PIN_I(gate_pin), .HIGH_EVENT_PIN_I(high_pin),
    .LOW_EVENT_PIN_I(low_pin), .PWM_GATE_SIGNAL_O(pwm_gate), .COUNT_GATE_O(count_gate),
    .IRQ_O(irq)
  );
  aec_pin_src u_src (.GATE_O(gate_pin), .HIGH_O(high_pin), .LOW_O(low_pin));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge CLK_SYS_I);
    REG_ADDR_I  <= a;
    REG_WDATA_I <= v;
    REG_WR_I    <= 1'b1;
    @(posedge CLK_SYS_I);
    REG_WR_I <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample it there
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] x,
                    input string what);
    @(posedge CLK_SYS_I);
    REG_ADDR_I <= a;
    REG_RD_I   <= 1'b1;
    @(posedge CLK_SYS_I);
    REG_RD_I <= 1'b0;
    #1 d = REG_RDATA_O;
    // A zero mask only samples the data for a later comparison
    if (m != 8'h00) begin
      check(what, d & m, x);
    end
  endtask : rd
  task automatic stop_test();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  always @(posedge CLK_SYS_I) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge CLK_SYS_I);
    RESET_N_I <= 1'b1;
    rd(OFS_EDGE_SEL, 8'hFF, RST_EDGE_SEL, "edge select reset");
    rd(OFS_CLK_CTL, 8'hFF, RST_CLK_CTL, "clock control reset");
    rd(OFS_CTL_STAT, 8'hFF, RST_CTL_STAT, "control status reset");
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'hFF, 8'h00, "unmapped read");
    for (int k = 0; k < 8; k++) begin
      e = {k[1:0], k[1:0], k[2:0], 1'b0};
      wr(OFS_CLK_CTL, e);
      rd(OFS_CLK_CTL, 8'hFF, e, "clock control");
    end
    wr(OFS_CTL_STAT, 8'hC0);
    rd(OFS_CTL_STAT, 8'hFF, 8'h00, "flags after write one");
    // Split mode, both counters at half rate: one wrap each
    wr(OFS_CLK_CTL, 8'h50);
    wr(OFS_CTL_STAT, 8'h1F);
    u_src.set_gate(1'b1);
    repeat (600) @(posedge CLK_SYS_I);
    u_src.set_gate(1'b0);
    wr(OFS_CTL_STAT, 8'h1F);
    rd(OFS_CTL_STAT, 8'hFF, 8'hDF, "flags without read");
    rd(OFS_CTL_STAT, 8'hC0, 8'hC0, "flags kept after read");
    wr(OFS_CTL_STAT, 8'h1F);
    rd(OFS_CTL_STAT, 8'hFF, 8'h1F, "flags after clear");
    // Both counters ran from the same half-rate tick under the same gate
    rd(OFS_HIGH_CNT, 8'h00, 8'h00, "high count sample");
    e = d;
    check("high count ran", {7'h00, e != 8'h00}, 8'h01);
    rd(OFS_LOW_CNT, 8'hFF, e, "low matches high");
    repeat (20) @(posedge CLK_SYS_I);
    rd(OFS_LOW_CNT, 8'hFF, e, "low count held");
    rd(OFS_IRQ_STAT, 8'h03, 8'h03, "overflow events");
    check("irq masked", {7'h00, irq}, 8'h00);
    wr(OFS_IRQ_MASK, 8'h03);
    repeat (2) @(posedge CLK_SYS_I);
    #1 check("irq raised", {7'h00, irq}, 8'h01);
    wr(OFS_IRQ_MASK, 8'h01);
    wr(OFS_IRQ_STAT, 8'h01);
    rd(OFS_IRQ_STAT, 8'h03, 8'h02, "status after clear");
    check("irq cleared", {7'h00, irq}, 8'h00);
    wr(OFS_IRQ_STAT, 8'h02);
    // Joined mode: a low wrap steps the high counter, no wide overflow yet
    wr(OFS_CTL_STAT, 8'h00);
    wr(OFS_CLK_CTL, 8'h10);
    wr(OFS_CTL_STAT, 8'h0F);
    u_src.set_gate(1'b1);
    repeat (600) @(posedge CLK_SYS_I);
    u_src.set_gate(1'b0);
    rd(OFS_HIGH_CNT, 8'hFF, 8'h01, "joined high count");
    rd(OFS_CTL_STAT, 8'h80, 8'h00, "no wide overflow");
    wr(OFS_CTL_STAT, 8'h10);
    wr(OFS_CLK_CTL, 8'h00);
    wr(OFS_CTL_STAT, 8'h1F);
    u_src.set_gate(1'b1);
    u_src.pulse(1'b1, 1'b1, 5);
    u_src.set_gate(1'b0);
    rd(OFS_LOW_CNT, 8'hFF, 8'h05, "pin event count");
    rd(OFS_HIGH_CNT, 8'hFF, 8'h05, "high pin event count");
    wr(OFS_IRQ_STAT, 8'h07);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_EDGE_SEL, es_tab[i]);
      u_src.set_gate(1'b1);
      rd(OFS_IRQ_STAT, 8'h04, {5'h00, rise_tab[i], 2'h0}, "gate rise");
      wr(OFS_IRQ_STAT, 8'h04);
      u_src.set_gate(1'b0);
      rd(OFS_IRQ_STAT, 8'h04, {5'h00, fall_tab[i], 2'h0}, "gate fall");
      wr(OFS_IRQ_STAT, 8'h04);
    end
    // PWM at half rate, period FF: high for about 254 cycles, then low
    check("pwm gate high", {7'h00, pwm_gate}, 8'h01);
    check("count gate pwm", {7'h00, count_gate}, 8'h01);
    repeat (300) @(posedge CLK_SYS_I);
    #1 check("pwm gate low", {7'h00, pwm_gate}, 8'h00);
    check("count gate pwm low", {7'h00, count_gate}, 8'h00);
    stop_test();
  end
endmodule : tb_top
